// ===== mfd_cfg.svh
`ifndef MFD_CFG_SVH
`define MFD_CFG_SVH

// Micro-flow class codes carried in the fetch marker.
`define MFD_CLS_W 4
`define MFD_CLS_NONE 4'h0
`define MFD_CLS_MOVT 4'h1
`define MFD_CLS_MOVQ 4'h2
`define MFD_CLS_ADDR 4'h3
`define MFD_CLS_LOAD 4'h4
`define MFD_CLS_STORE 4'h5
`define MFD_CLS_FSET 4'h6
`define MFD_CLS_FCLR 4'h7
`define MFD_CLS_FEXT 4'h8
`define MFD_CLS_FMOD 4'h9

// Addressing-mode groups.
`define MFD_AM_W 2
`define MFD_AM_PLAIN 2'h0
`define MFD_AM_SCALED 2'h1
`define MFD_AM_INDEXED 2'h2
`define MFD_AM_IPREL 2'h3

// Instruction format codes.
`define MFD_FMT_W 2
`define MFD_FMT_REG 2'h0
`define MFD_FMT_MEM 2'h1
`define MFD_FMT_CTRL 2'h2
`define MFD_FMT_CMPBR 2'h3

// Issue clock counts of each micro-flow.
`define MFD_CLK_MOV 4'h2
`define MFD_CLK_ADDR_IDX 4'h2
`define MFD_CLK_ADDR_IP 4'h4
`define MFD_CLK_LS_SCALED 4'h1
`define MFD_CLK_LS_INDEXED 4'h2
`define MFD_CLK_LS_IPREL 4'h4
`define MFD_CLK_FSET 4'h1
`define MFD_CLK_FCLR 4'h2
`define MFD_CLK_FEXT 4'h4
`define MFD_CLK_FMOD 4'h3

// Opcode, mode-group and format fields of the instruction word.
`define MFD_OPC_HI 31
`define MFD_OPC_LO 24
`define MFD_AM_HI 13
`define MFD_AM_LO 12
`define MFD_FMT_HI 29
`define MFD_FMT_LO 28

`endif

// ===== mfd_dispatch.sv
// Behaviour
// RQ1 - Mark complex instructions in the fetch clock; store marker with encoding.
// RQ2 - Lookahead decodes the next instruction; next clock offers its ROM words.
// RQ3 - Never offer a complex encoding for issue; trap to ROM instead.
// RQ4 - Successful lookahead enters a micro-flow with no lost issue clock.
// RQ5 - Branch targets or straight-line misses defeat lookahead: one idle clock.
// RQ6 - Load/store format micro-flows never take the idle clock.
// RQ7 - Returning or chaining micro-flows adds no overhead clock.
// RQ8 - ROM words are simple three-operand, load/store or branch instructions.
// RQ9 - ROM issues two words per clock, memory side beside register side.
// RQ10 - Triple and quad register moves take two issue clocks.
// RQ11 - Address compute in scaled-index modes takes two clocks.
// RQ12 - Address compute in IP-relative mode takes four clocks.
// RQ13 - Other address compute modes go straight to the address generator.
// RQ14 - Loads add 1, 2 or 4 address clocks by mode group.
// RQ15 - Stores add 1, 2 or 4 address clocks by mode group.
// RQ16 - Plain offset, displacement and register-indirect add no clocks.
// RQ17 - Micro-flowed loads and stores pair with a three-operand instruction.
// RQ18 - Find-set 1, find-clear 2, field extract 4, field modify 3 clocks.
// RQ19 - A word arriving after a miss may issue in its arrival clock.
// RQ20 - Fixed table maps opcode class and mode group to ROM entry.
`timescale 1ns/1ns
`include "mfd_cfg.svh"

module mfd_dispatch #(
   parameter int ROM_AW = 6
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Fetch side: raw words from cache or bus unit.
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_word,
   input wire logic fetch_from_bus,
   input wire logic fetch_branch_tgt,
   // Lookahead side: the next executable instruction with its stored marker.
   input wire logic next_valid,
   input wire logic [31:0] next_word,
   input wire logic [`MFD_CLS_W-1:0] next_mark,
   input wire logic next_defeated,
   // Dispatch unit side.
   input wire logic dispatch_ready,
   // Marker written with the encoding into queue and cache.
   output logic mark_valid,
   output logic [31:0] mark_word,
   output logic [`MFD_CLS_W-1:0] mark_class,
   // Words offered for issue: register side and memory side.
   output logic issue_valid,
   output logic [31:0] issue_reg_word,
   output logic [31:0] issue_mem_word,
   output logic issue_mem_valid,
   output logic issue_idle,
   output logic in_flow,
   output logic consume_next
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions.

   // Classify a fetched word from opcode and mode group.
   function automatic logic [`MFD_CLS_W-1:0] classify(input logic [31:0] w);
      logic [7:0] op;
      logic [`MFD_AM_W-1:0] am;
      op = w[`MFD_OPC_HI:`MFD_OPC_LO];
      am = w[`MFD_AM_HI:`MFD_AM_LO];
      classify = `MFD_CLS_NONE;
      unique case (op)
         8'h5E: classify = `MFD_CLS_MOVT;
         8'h5F: classify = `MFD_CLS_MOVQ;
         8'h8C: classify = (am == `MFD_AM_INDEXED || am == `MFD_AM_IPREL) ?
                           `MFD_CLS_ADDR : `MFD_CLS_NONE; // RQ13
         8'h90: classify = (am == `MFD_AM_PLAIN) ? `MFD_CLS_NONE : `MFD_CLS_LOAD; // RQ16
         8'h92: classify = (am == `MFD_AM_PLAIN) ? `MFD_CLS_NONE : `MFD_CLS_STORE; // RQ16
         8'h64: classify = `MFD_CLS_FSET;
         8'h65: classify = `MFD_CLS_FCLR;
         8'h66: classify = `MFD_CLS_FEXT;
         8'h67: classify = `MFD_CLS_FMOD;
         default: classify = `MFD_CLS_NONE;
      endcase
   endfunction

   // Issue clocks of a micro-flow.
   function automatic logic [3:0] flow_len(input logic [`MFD_CLS_W-1:0] c,
                                           input logic [`MFD_AM_W-1:0] am);
      flow_len = 4'h1;
      unique case (c)
         `MFD_CLS_MOVT, `MFD_CLS_MOVQ: flow_len = `MFD_CLK_MOV; // RQ10
         `MFD_CLS_ADDR: flow_len = (am == `MFD_AM_IPREL) ?
                                   `MFD_CLK_ADDR_IP : `MFD_CLK_ADDR_IDX; // RQ11 RQ12
         `MFD_CLS_LOAD, `MFD_CLS_STORE: begin // RQ14 RQ15
            unique case (am)
               `MFD_AM_SCALED: flow_len = `MFD_CLK_LS_SCALED;
               `MFD_AM_INDEXED: flow_len = `MFD_CLK_LS_INDEXED;
               default: flow_len = `MFD_CLK_LS_IPREL;
            endcase
         end
         `MFD_CLS_FSET: flow_len = `MFD_CLK_FSET; // RQ18
         `MFD_CLS_FCLR: flow_len = `MFD_CLK_FCLR; // RQ18
         `MFD_CLS_FEXT: flow_len = `MFD_CLK_FEXT; // RQ18
         `MFD_CLS_FMOD: flow_len = `MFD_CLK_FMOD; // RQ18
         default: flow_len = 4'h1;
      endcase
   endfunction

   // Entry of each flow in the ROM, by class and mode group.
   // Flows lie end to end, so no two flows ever share a ROM word; 34 words are used.
   function automatic logic [ROM_AW-1:0] rom_entry(input logic [`MFD_CLS_W-1:0] c,
                                                   input logic [`MFD_AM_W-1:0] am);
      logic [5:0] e;
      e = 6'h00;
      unique case (c)
         `MFD_CLS_MOVT: e = 6'h00;
         `MFD_CLS_MOVQ: e = 6'h02;
         `MFD_CLS_ADDR: e = (am == `MFD_AM_IPREL) ? 6'h06 : 6'h04;
         `MFD_CLS_LOAD: begin
            unique case (am)
               `MFD_AM_SCALED: e = 6'h0A;
               `MFD_AM_INDEXED: e = 6'h0B;
               default: e = 6'h0D;
            endcase
         end
         `MFD_CLS_STORE: begin
            unique case (am)
               `MFD_AM_SCALED: e = 6'h11;
               `MFD_AM_INDEXED: e = 6'h12;
               default: e = 6'h14;
            endcase
         end
         `MFD_CLS_FSET: e = 6'h18;
         `MFD_CLS_FCLR: e = 6'h19;
         `MFD_CLS_FEXT: e = 6'h1B;
         `MFD_CLS_FMOD: e = 6'h1F;
         default: e = 6'h00;
      endcase
      rom_entry = ROM_AW'(e); // RQ20
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Micro-flow ROM: simple register and memory words, two per clock.

   // One register-side and one memory-side word per entry.
   logic [63:0] rom [0:(1<<ROM_AW)-1];

   // The ROM content holds only simple register and memory-side opcodes.
   always_comb begin
      for (int i = 0; i < (1 << ROM_AW); i++) begin
         rom[i] = {8'h58, 24'(i), 8'h80, 24'(i)}; // RQ8 RQ9
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fetch marking.

   // Marker registers, one clock behind the fetch.
   logic mark_valid_q, mark_valid_d;
   logic [31:0] mark_word_q, mark_word_d;
   logic [`MFD_CLS_W-1:0] mark_class_q, mark_class_d;

   // Classify in the fetch clock and hand the marker on with the word.
   always_comb begin
      mark_valid_d = fetch_valid;
      mark_word_d = fetch_word;
      mark_class_d = classify(fetch_word); // RQ1
   end

   // Register the marker; reset clears it.
   always_ff @(posedge clk) begin
      if (srst) begin
         mark_valid_q <= 1'b0;
         mark_word_q <= 32'h0;
         mark_class_q <= `MFD_CLS_NONE;
      end else begin
         mark_valid_q <= mark_valid_d;
         mark_word_q <= mark_word_d;
         mark_class_q <= mark_class_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Dispatch sequencer.

   // Sequencer state, the current flow and the words on offer.
   mfd_pkg::mfd_state_t state_q, state_d;
   logic [3:0] left_q, left_d;
   logic [ROM_AW-1:0] addr_q, addr_d;
   logic [`MFD_CLS_W-1:0] cls_q, cls_d;
   logic [`MFD_AM_W-1:0] am_q, am_d;
   logic [31:0] reg_q, reg_d;
   logic [31:0] mem_q, mem_d;
   // Issue flags, each registered straight to an output.
   logic iv_q, iv_d;
   logic mv_q, mv_d;
   logic idle_q, idle_d;
   logic flow_q, flow_d;
   logic take_q, take_d;
   // Lookahead decode of the next instruction.
   logic is_flow, is_mem_fmt, busy;
   logic [`MFD_AM_W-1:0] nam;

   // Lookahead decode of the next instruction and the next-clock offer.
   always_comb begin
      nam = next_word[`MFD_AM_HI:`MFD_AM_LO];
      is_flow = next_valid && (next_mark != `MFD_CLS_NONE);
      is_mem_fmt = (next_word[`MFD_FMT_HI:`MFD_FMT_LO] == `MFD_FMT_MEM);
      busy = (state_q == mfd_pkg::MFD_FLOW) && (left_q > 4'h1);
      // By default hold the flow and offer nothing.
      state_d = state_q;
      left_d = left_q;
      addr_d = addr_q;
      cls_d = cls_q;
      am_d = am_q;
      reg_d = reg_q;
      mem_d = mem_q;
      iv_d = 1'b0;
      mv_d = 1'b0;
      idle_d = 1'b0;
      flow_d = 1'b0;
      take_d = 1'b0;
      if (!dispatch_ready) begin
         // Hold every offer while the dispatch unit stalls.
         iv_d = iv_q;
         mv_d = mv_q;
         idle_d = idle_q;
         flow_d = flow_q;
      end else begin
         unique case (state_q)
            mfd_pkg::MFD_FLOW: begin
               if (busy) begin
                  // Keep issuing ROM pairs until the flow is spent.
                  left_d = left_q - 4'h1;
                  addr_d = addr_q + ROM_AW'(1);
                  reg_d = rom[addr_d][63:32];
                  mem_d = rom[addr_d][31:0];
                  iv_d = 1'b1;
                  mv_d = 1'b1; // RQ9 RQ17
                  flow_d = 1'b1;
               end else begin
                  state_d = mfd_pkg::MFD_RUN; // RQ7
               end
            end
            mfd_pkg::MFD_BREAK: begin
               // Idle clock spent; enter the flow now.
               state_d = mfd_pkg::MFD_FLOW; // RQ5
               left_d = flow_len(cls_q, am_q);
               addr_d = rom_entry(cls_q, am_q);
               reg_d = rom[addr_d][63:32];
               mem_d = rom[addr_d][31:0];
               iv_d = 1'b1;
               mv_d = 1'b1;
               flow_d = 1'b1;
            end
            default: begin
               state_d = mfd_pkg::MFD_RUN;
            end
         endcase
         // The issue slot is free: take the next instruction.
         if (!busy && state_q != mfd_pkg::MFD_BREAK && next_valid) begin
            take_d = 1'b1;
            cls_d = next_mark;
            am_d = nam;
            // A flow chained behind a flow, or a memory format, never idles.
            if (is_flow && next_defeated && !is_mem_fmt &&
                state_q != mfd_pkg::MFD_FLOW) begin // RQ6 RQ7
               state_d = mfd_pkg::MFD_BREAK; // RQ5
               idle_d = 1'b1;
            end else if (is_flow) begin
               state_d = mfd_pkg::MFD_FLOW; // RQ2 RQ4
               left_d = flow_len(next_mark, nam);
               addr_d = rom_entry(next_mark, nam);
               reg_d = rom[addr_d][63:32]; // RQ3
               mem_d = rom[addr_d][31:0];
               iv_d = 1'b1;
               mv_d = 1'b1;
               flow_d = 1'b1;
            end else begin
               // Simple word, including one just arriving from the bus.
               state_d = mfd_pkg::MFD_RUN; // RQ19
               reg_d = next_word;
               mem_d = 32'h0;
               iv_d = 1'b1;
            end
         end
      end
   end

   // Register the sequencer; reset leaves it idle with nothing on offer.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= mfd_pkg::MFD_RUN;
         left_q <= 4'h0;
         addr_q <= '0;
         cls_q <= `MFD_CLS_NONE;
         am_q <= `MFD_AM_PLAIN;
         reg_q <= 32'h0;
         mem_q <= 32'h0;
         iv_q <= 1'b0;
         mv_q <= 1'b0;
         idle_q <= 1'b0;
         flow_q <= 1'b0;
         take_q <= 1'b0;
      end else begin
         state_q <= state_d;
         left_q <= left_d;
         addr_q <= addr_d;
         cls_q <= cls_d;
         am_q <= am_d;
         reg_q <= reg_d;
         mem_q <= mem_d;
         iv_q <= iv_d;
         mv_q <= mv_d;
         idle_q <= idle_d;
         flow_q <= flow_d;
         take_q <= take_d;
      end
   end

   // Outputs straight from flip-flops.
   assign mark_valid = mark_valid_q;
   assign mark_word = mark_word_q;
   assign mark_class = mark_class_q;
   assign issue_valid = iv_q;
   assign issue_reg_word = reg_q;
   assign issue_mem_word = mem_q;
   assign issue_mem_valid = mv_q;
   assign issue_idle = idle_q;
   assign in_flow = flow_q;
   assign consume_next = take_q;

endmodule // mfd_dispatch

// ===== mfd_dispatch_monitor.sv
`timescale 1ns/1ns
`include "mfd_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Checks issue timing of the dispatch block at its ports.
module mfd_dispatch_monitor (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Fetch and lookahead side.
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_word,
   input wire logic [31:0] next_word,
   input wire logic [`MFD_CLS_W-1:0] next_mark,
   input wire logic next_defeated,
   input wire logic dispatch_ready,
   // Marker and issue side.
   input wire logic mark_valid,
   input wire logic [31:0] mark_word,
   input wire logic issue_valid,
   input wire logic [31:0] issue_reg_word,
   input wire logic issue_mem_valid,
   input wire logic issue_idle,
   input wire logic in_flow,
   input wire logic consume_next
);
   logic [3:0] mk_q, len_q, cnt_q, len_d, cnt_d, exp_len;
   logic [31:0] wd_q;
   logic df_q, fl_q, rdy_q;
   // Works out the flow length of the instruction taken one clock ago.
   always_comb begin
      case (mk_q)
         `MFD_CLS_MOVT, `MFD_CLS_MOVQ: exp_len = 4'h2;
         `MFD_CLS_ADDR: exp_len = (wd_q[13:12] == 2'h2) ? 4'h2 : {1'b0, wd_q[13:12] == 2'h3, 2'h0};
         `MFD_CLS_LOAD, `MFD_CLS_STORE: exp_len = (wd_q[13:12] == 2'h3) ? 4'h4 : {2'h0, wd_q[13:12]};
         `MFD_CLS_FSET: exp_len = 4'h1;
         `MFD_CLS_FCLR: exp_len = 4'h2;
         `MFD_CLS_FEXT: exp_len = 4'h4;
         `MFD_CLS_FMOD: exp_len = 4'h3;
         default: exp_len = 4'h0;
      endcase
      len_d = (consume_next && dispatch_ready) ? exp_len : len_q;
      cnt_d = consume_next ? {3'h0, in_flow} : cnt_q + {3'h0, in_flow};
      if (!dispatch_ready) cnt_d = cnt_q;
   end
   // Remembers what was offered and issued one clock ago.
   always_ff @(posedge clk) begin
      if (srst) begin
         mk_q <= 4'h0;
         wd_q <= 32'h0;
         {df_q, fl_q, rdy_q, len_q, cnt_q} <= 11'h0;
      end else begin
         mk_q <= next_mark;
         wd_q <= next_word;
         {df_q, fl_q, rdy_q, len_q, cnt_q} <= {next_defeated, in_flow, dispatch_ready, len_d, cnt_d};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_take;
      consume_next && exp_len != 4'h0;
   endsequence
   sequence s_cold;
      s_take ##0 (df_q && wd_q[29:28] != `MFD_FMT_MEM && !fl_q && dispatch_ready);
   endsequence
   property p_mark;
      fetch_valid |=> mark_valid && mark_word == $past(fetch_word);
   endproperty
   property p_direct;
      consume_next && exp_len == 4'h0 |-> issue_valid && !in_flow && issue_reg_word == wd_q;
   endproperty
   property p_trap;
      s_take |-> in_flow || issue_idle;
   endproperty
   property p_warm;
      s_take ##0 (!df_q || wd_q[29:28] == `MFD_FMT_MEM || fl_q) |-> in_flow && !issue_idle;
   endproperty
   property p_cold;
      s_cold |-> issue_idle ##1 (in_flow && !issue_idle);
   endproperty
   property p_idle_cause;
      issue_idle && !$past(issue_idle) |-> df_q && wd_q[29:28] != `MFD_FMT_MEM && !fl_q;
   endproperty
   property p_pair;
      in_flow && issue_valid |-> issue_mem_valid;
   endproperty
   property p_len_short;
      in_flow && !consume_next |-> cnt_q < len_q;
   endproperty
   property p_len_end;
      fl_q && rdy_q && (!in_flow || consume_next) |-> cnt_q == len_q;
   endproperty
   a_mark: assert property (p_mark) else $error("marker missing");
   a_direct: assert property (p_direct) else $error("direct issue wrong");
   a_trap: assert property (p_trap) else $error("complex word issued");
   a_warm: assert property (p_warm) else $error("clock lost on entry");
   a_cold: assert property (p_cold) else $error("break clock wrong");
   a_idle_cause: assert property (p_idle_cause) else $error("stray break");
   a_pair: assert property (p_pair) else $error("flow word unpaired");
   a_len_short: assert property (p_len_short) else $error("flow too long");
   a_len_end: assert property (p_len_end) else $error("flow length wrong");
endmodule // mfd_dispatch_monitor

bind mfd_dispatch mfd_dispatch_monitor mfd_dispatch_monitor_inst (.clk(clk), .srst(srst),
   .fetch_valid(fetch_valid), .fetch_word(fetch_word), .next_word(next_word),
   .next_mark(next_mark), .next_defeated(next_defeated), .dispatch_ready(dispatch_ready),
   .mark_valid(mark_valid), .mark_word(mark_word), .issue_valid(issue_valid),
   .issue_reg_word(issue_reg_word), .issue_mem_valid(issue_mem_valid),
   .issue_idle(issue_idle), .in_flow(in_flow), .consume_next(consume_next));

// ===== mfd_dispatch_tb.sv
`timescale 1ns/1ns
`include "mfd_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Bench for the micro-flow dispatch block.
module mfd_dispatch_tb;
   logic clk, srst, fetch_valid, fetch_from_bus, fetch_branch_tgt, dispatch_ready, push, pd;
   logic [31:0] fetch_word, next_word, mark_word, issue_reg_word, issue_mem_word, pw;
   logic [3:0] next_mark, mark_class, pm;
   logic next_valid, next_defeated, mark_valid, issue_valid, issue_mem_valid, issue_idle;
   logic in_flow, consume_next;
   int error_cnt, checked;
   mfd_dispatch mfd_dispatch_inst (.clk(clk), .srst(srst), .fetch_valid(fetch_valid),
      .fetch_word(fetch_word), .fetch_from_bus(fetch_from_bus),
      .fetch_branch_tgt(fetch_branch_tgt), .next_valid(next_valid), .next_word(next_word),
      .next_mark(next_mark), .next_defeated(next_defeated), .dispatch_ready(dispatch_ready),
      .mark_valid(mark_valid), .mark_word(mark_word), .mark_class(mark_class),
      .issue_valid(issue_valid), .issue_reg_word(issue_reg_word),
      .issue_mem_word(issue_mem_word), .issue_mem_valid(issue_mem_valid),
      .issue_idle(issue_idle), .in_flow(in_flow), .consume_next(consume_next));
   mfd_fetch_model mfd_fetch_model_inst (.clk(clk), .srst(srst), .push(push), .push_word(pw),
      .push_mark(pm), .push_defeat(pd), .consume_next(consume_next), .next_valid(next_valid),
      .next_word(next_word), .next_mark(next_mark), .next_defeated(next_defeated));
   // Shared helpers: compare, step, load and measure.
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // True for an opcode that is complex and must never reach the dispatch unit.
   function automatic logic cplx(input logic [31:0] w);
      cplx = w[31:24] inside {8'h5E, 8'h5F, 8'h8C, 8'h90, 8'h92, 8'h64, 8'h65, 8'h66, 8'h67};
   endfunction
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic put(input logic [1:0] fmt, input logic [1:0] am, input logic [3:0] mk,
                      input logic df);
      pw = {2'h0, fmt, 14'h0, am, 12'h5A1};
      pm = mk;
      pd = df;
      push = 1'b1; // Held high; the caller lowers it once loading is done.
      step();
   endtask
   task automatic meas(input int n, input int idl);
      int fl, id, k;
      fl = 0;
      id = 0;
      k = 0;
      push = 1'b0;
      while (consume_next !== 1'b1 && k < 20) begin
         step();
         k++;
      end
      chk("taken", 1, consume_next);
      chk("issue valid", idl == 0, issue_valid);
      if (n == 0) chk("direct word", pw, issue_reg_word);
      do begin
         fl += int'(in_flow);
         id += int'(issue_idle);
         if (in_flow === 1'b1) begin
            chk("flow pair", 1, issue_mem_valid);
            chk("rom reg word", 0, cplx(issue_reg_word));
            chk("rom mem word", 0, cplx(issue_mem_word));
         end
         step();
      end while (in_flow === 1'b1 || issue_idle === 1'b1);
      chk("flow clocks", n, fl);
      chk("idle clocks", idl, id);
   endtask
   task automatic run(input logic [1:0] fmt, input logic [1:0] am, input logic [3:0] mk,
                      input logic df, input int n, input int idl);
      put(fmt, am, mk, df);
      meas(n, idl);
   endtask
   // Scenarios.
   task automatic t_fetch();
      logic [31:0] w [6] = '{32'h0012_3456, 32'h8C00_1000, 32'h8C00_2000, 32'h9000_0000,
                             32'h9200_3000, 32'h6600_0000};
      logic [3:0] c [6] = '{`MFD_CLS_NONE, `MFD_CLS_NONE, `MFD_CLS_ADDR, `MFD_CLS_NONE,
                            `MFD_CLS_STORE, `MFD_CLS_FEXT};
      fetch_valid = 1'b1;
      fetch_from_bus = 1'b1;
      for (int i = 0; i < 6; i++) begin
         fetch_word = w[i];
         step();
         chk("mark valid", 1, mark_valid);
         chk("mark word", w[i], mark_word);
         chk("mark class", c[i], mark_class);
      end
      fetch_valid = 1'b0;
   endtask
   task automatic t_data();
      logic [3:0] n [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
      run(`MFD_FMT_REG, 2'h0, `MFD_CLS_MOVT, 1'b0, 2, 0);
      run(`MFD_FMT_REG, 2'h0, `MFD_CLS_MOVQ, 1'b0, 2, 0);
      // Fetch leaves scaled address compute and plain loads and stores unmarked.
      run(`MFD_FMT_MEM, 2'h1, `MFD_CLS_NONE, 1'b0, 0, 0);
      run(`MFD_FMT_MEM, 2'h2, `MFD_CLS_ADDR, 1'b0, 2, 0);
      run(`MFD_FMT_MEM, 2'h3, `MFD_CLS_ADDR, 1'b0, 4, 0);
      for (int a = 0; a < 4; a++) begin
         run(`MFD_FMT_MEM, a[1:0], (a == 0) ? `MFD_CLS_NONE : `MFD_CLS_LOAD, 1'b1,
             n[a], 0);
         run(`MFD_FMT_MEM, a[1:0], (a == 0) ? `MFD_CLS_NONE : `MFD_CLS_STORE, 1'b0,
             n[a], 0);
      end
   endtask
   task automatic t_bits();
      run(`MFD_FMT_REG, 2'h0, `MFD_CLS_FSET, 1'b0, 1, 0);
      run(`MFD_FMT_REG, 2'h0, `MFD_CLS_FCLR, 1'b0, 2, 0);
      run(`MFD_FMT_REG, 2'h0, `MFD_CLS_FEXT, 1'b0, 4, 0);
      run(`MFD_FMT_REG, 2'h0, `MFD_CLS_FMOD, 1'b0, 3, 0);
      run(`MFD_FMT_REG, 2'h0, `MFD_CLS_FEXT, 1'b1, 4, 1);
      run(`MFD_FMT_CMPBR, 2'h0, `MFD_CLS_FCLR, 1'b1, 2, 1);
   endtask
   task automatic t_chain();
      dispatch_ready = 1'b0;
      put(`MFD_FMT_REG, 2'h0, `MFD_CLS_MOVT, 1'b0);
      put(`MFD_FMT_CTRL, 2'h0, `MFD_CLS_FMOD, 1'b1);
      put(`MFD_FMT_REG, 2'h0, `MFD_CLS_NONE, 1'b0);
      push = 1'b0;
      repeat (3) step();
      chk("stalled issue", 0, issue_valid);
      chk("stalled take", 0, consume_next);
      dispatch_ready = 1'b1;
      meas(5, 0);
      chk("return word", pw, issue_reg_word);
   endtask
   // Verdict and end of run.
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Clock of 8 ns.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Watchdog against a hang.
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      {srst, fetch_valid, fetch_from_bus, fetch_branch_tgt, push, pd} = 6'h21;
      {fetch_word, pw, pm} = 68'h0;
      dispatch_ready = 1'b1;
      error_cnt = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      #1 srst = 1'b0;
      t_fetch();
      t_data();
      t_bits();
      t_chain();
      end_of_test();
   end
endmodule // mfd_dispatch_tb

// ===== mfd_fetch_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Fetch queue that feeds the lookahead port.
module mfd_fetch_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Loading port.
   input wire logic push,
   input wire logic [31:0] push_word,
   input wire logic [3:0] push_mark,
   input wire logic push_defeat,
   // Lookahead port.
   input wire logic consume_next,
   output logic next_valid,
   output logic [31:0] next_word,
   output logic [3:0] next_mark,
   output logic next_defeated
);
   logic [31:0] w_a [16];
   logic [3:0] m_a [16];
   logic d_a [16];
   logic [3:0] rd_q, wr_q, hd, cyc_q;
   // The entry after a taken one shows at once, so lookahead sees it.
   assign hd = rd_q + {3'h0, consume_next};
   assign next_valid = hd != wr_q;
   assign next_word = next_valid ? w_a[hd] : {8{cyc_q}};
   assign next_mark = next_valid ? m_a[hd] : cyc_q;
   assign next_defeated = next_valid ? d_a[hd] : cyc_q[0];
   // Pointers move on a push and on each taken entry.
   always @(posedge clk) begin
      cyc_q <= cyc_q + 4'h1;
      if (srst) begin
         rd_q <= 4'h0;
         wr_q <= 4'h0;
      end else begin
         rd_q <= hd;
         if (push) begin
            w_a[wr_q] <= push_word;
            m_a[wr_q] <= push_mark;
            d_a[wr_q] <= push_defeat;
            wr_q <= wr_q + 4'h1;
         end
      end
   end
   initial cyc_q = 4'h0;
endmodule // mfd_fetch_model

// ===== mfd_pkg.sv
package mfd_pkg;
   // Dispatch sequencing states, Gray coded from MFD_RUN through MFD_BREAK to MFD_FLOW.
   typedef enum logic [1:0] {
      MFD_RUN = 2'b00,
      MFD_BREAK = 2'b01,
      MFD_FLOW = 2'b11
   } mfd_state_t;
endpackage
